// ---- common/wfd_pkg.sv ----
package wfd_pkg;
  // register addresses
  localparam logic [15:0] ADDR_IRQ_STATUS_TWO = 16'h0013;
  localparam logic [15:0] ADDR_WAKE_RX_CONFIG = 16'h04A0;
  localparam logic [15:0] ADDR_WAKE_RX_STATUS = 16'h04A1;
  // wake_rx_config fields
  localparam int CFG_MAGIC_EN = 0;
  localparam int CFG_PASS_EN = 1;
  localparam int CFG_PAT_EN = 2;
  localparam int CFG_BCAST_EN = 3;
  localparam int CFG_LEVEL_MODE = 4;
  localparam int CFG_PIN_EN = 5;
  localparam int CFG_WAKE_EN = 7;
  localparam int CFG_PIN_SEL = 8;
  localparam int CFG_LEVEL_CLR = 10;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_TYPE_MASK = 16'h0007;
  // wake_rx_status fields
  localparam int ST_MAGIC_HIT = 0;
  localparam int ST_PASS_HIT = 1;
  localparam int ST_PAT_HIT = 2;
  localparam int ST_CRC_DROP = 3;
  localparam logic [3:0] STAT_RESET = 4'h0;
  // interrupt_status_two fields
  localparam int IRQ_WAKE_EN = 0;
  localparam int IRQ_WAKE_PEND = 8;
  // frame structure
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [3:0] REPS_LAST = 4'hF;
  localparam logic [6:0] PAT_LEN = 7'h40;
  localparam logic [6:0] SA_FIRST = 7'h06;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_NS = 400;
  localparam logic [3:0] PULSE_CYCLES =
    4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    WFD_SYNC, WFD_ADDR, WFD_PASS, WFD_FOUND
  } wfd_state_t;
endpackage

// ---- common/wfd_mem_if.sv ----
`timescale 1ns/1ps
interface wfd_mem_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl(output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem(input wr_en, input wr_addr, input wr_data,
              input rd_addr, output rd_data);
endinterface

// ---- rtl/wfd_pattern_mem.sv ----
`timescale 1ns/1ps
module wfd_pattern_mem (
  input wire logic sys_clk,
  input wire logic arst_n,
  wfd_mem_if.mem mem
);
  logic [7:0] store_q [64];
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  assign rd_d = store_q[mem.rd_addr];
  assign mem.rd_data = rd_q;

  always_ff @(posedge sys_clk) begin
    if (mem.wr_en) begin
      store_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end
endmodule // wfd_pattern_mem

// ---- rtl/wfd_detector.sv ----
`timescale 1ns/1ps
// Contract
// - detect basic wake, wake with password, and pattern frames
// - when configured, scan every frame addressed to this node
// - accept own or broadcast destination with valid source and CRC
// - six 0xFF bytes must precede the address run
// - node address repeated sixteen times back to back
// - password enabled: password must follow the sixteenth copy
// - sync run and address run may start at any byte
// - custom pattern compares the first 64 frame bytes
// - byte stream matching, identical at every line speed
// - bad CRC suppresses wake event and interrupt
// - wake drives pulse or level on selected pin, or sets flag
// - settings at 0x04A0, results at 0x04A1
// - wake interrupt enable and pending at 0x0013
// - wake enable bit alone detects nothing
module wfd_detector
  import wfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic [47:0] node_addr,
  input wire logic [47:0] wake_password,
  input wire logic pat_wr,
  input wire logic [5:0] pat_addr,
  input wire logic [7:0] pat_data,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic [3:0] wake_gpio,
  output logic wake_flag
);
  function automatic logic [7:0] pick_byte(input logic [47:0] v,
                                           input logic [2:0] i);
    logic [47:0] sh;
    sh = v << (8 * i);
    return sh[47:40];
  endfunction

  wfd_mem_if mif ();
  wfd_pattern_mem u_mem (.sys_clk(sys_clk), .arst_n(arst_n), .mem(mif));

  ////////////////////////////////////////////////////////////////////////
  // input stage aligned with pattern read data
  logic [6:0] ridx_q, ridx_d, s_idx_q;
  logic s_vld_q, s_end_q, s_crc_q;
  logic [7:0] s_byte_q;
  logic is_ff;

  assign mif.wr_en = pat_wr;
  assign mif.wr_addr = pat_addr;
  assign mif.wr_data = pat_data;
  assign mif.rd_addr = ridx_q[5:0];
  assign is_ff = (s_byte_q == SYNC_BYTE);

  always_comb begin
    ridx_d = ridx_q;
    if (rx_end) begin
      ridx_d = 7'h00;
    end else if (rx_byte_valid && ridx_q != 7'h7F) begin
      ridx_d = ridx_q + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ridx_q <= 7'h00;
      s_idx_q <= 7'h00;
      s_vld_q <= 1'b0;
      s_end_q <= 1'b0;
      s_crc_q <= 1'b0;
      s_byte_q <= 8'h00;
    end else begin
      ridx_q <= ridx_d;
      s_idx_q <= ridx_q;
      s_vld_q <= rx_byte_valid;
      s_end_q <= rx_end;
      s_crc_q <= rx_crc_ok;
      s_byte_q <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake sequence matcher
  wfd_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [3:0] rep_q, rep_d;
  logic [15:0] cfg_q, cfg_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rep_d = rep_q;
    if (s_end_q) begin
      st_d = WFD_SYNC;
      cnt_d = 3'h0;
      rep_d = 4'h0;
    end else if (s_vld_q) begin
      unique case (st_q)
        WFD_SYNC: begin
          if (cnt_q == SYNC_LEN) begin
            if (s_byte_q == pick_byte(node_addr, 3'h0)) begin
              st_d = WFD_ADDR;
              cnt_d = 3'h1;
              rep_d = 4'h0;
            end else if (!is_ff) begin
              cnt_d = 3'h0;
            end
          end else begin
            cnt_d = is_ff ? cnt_q + 3'h1 : 3'h0;
          end
        end
        WFD_ADDR: begin
          if (s_byte_q == pick_byte(node_addr, cnt_q)) begin
            cnt_d = (cnt_q == ADDR_LAST) ? 3'h0 : cnt_q + 3'h1;
            if (cnt_q == ADDR_LAST) begin
              rep_d = rep_q + 4'h1;
              if (rep_q == REPS_LAST) begin
                st_d = cfg_q[CFG_PASS_EN] ? WFD_PASS : WFD_FOUND;
              end
            end
          end else begin
            st_d = WFD_SYNC;
            cnt_d = {2'b00, is_ff};
          end
        end
        WFD_PASS: begin
          if (s_byte_q == pick_byte(wake_password, cnt_q)) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ADDR_LAST) begin
              st_d = WFD_FOUND;
            end
          end else begin
            st_d = WFD_SYNC;
            cnt_d = {2'b00, is_ff};
          end
        end
        WFD_FOUND: st_d = WFD_FOUND;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= WFD_SYNC;
      cnt_q <= 3'h0;
      rep_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rep_q <= rep_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address fields and custom pattern
  logic da_own_q, da_own_d, da_bc_q, da_bc_d, sa_ok_q, sa_ok_d;
  logic pat_ok_q, pat_ok_d;

  always_comb begin
    da_own_d = da_own_q;
    da_bc_d = da_bc_q;
    sa_ok_d = sa_ok_q;
    pat_ok_d = pat_ok_q;
    if (s_end_q) begin
      da_own_d = 1'b1;
      da_bc_d = 1'b1;
      sa_ok_d = 1'b1;
      pat_ok_d = 1'b1;
    end else if (s_vld_q) begin
      // own or broadcast destination, unicast source
      if (s_idx_q < SA_FIRST) begin
        da_own_d = da_own_q &&
          (s_byte_q == pick_byte(node_addr, s_idx_q[2:0]));
        da_bc_d = da_bc_q && is_ff;
      end
      if (s_idx_q == SA_FIRST) begin
        sa_ok_d = !s_byte_q[0];
      end
      if (s_idx_q < PAT_LEN) begin
        pat_ok_d = pat_ok_q && (s_byte_q == mif.rd_data);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      da_own_q <= 1'b1;
      da_bc_q <= 1'b1;
      sa_ok_q <= 1'b1;
      pat_ok_q <= 1'b1;
    end else begin
      da_own_q <= da_own_d;
      da_bc_q <= da_bc_d;
      sa_ok_q <= sa_ok_d;
      pat_ok_q <= pat_ok_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame verdict
  logic magic_hit, pass_hit, pat_hit, addr_ok, frame_hit, wake_now;
  logic crc_drop;

  assign magic_hit = cfg_q[CFG_MAGIC_EN] && !cfg_q[CFG_PASS_EN] &&
                     st_q == WFD_FOUND;
  assign pass_hit = cfg_q[CFG_MAGIC_EN] && cfg_q[CFG_PASS_EN] &&
                    st_q == WFD_FOUND;
  assign pat_hit = cfg_q[CFG_PAT_EN] && pat_ok_q && s_idx_q >= PAT_LEN;
  // only frames addressed to this node, or broadcast when enabled
  assign addr_ok = (da_own_q || (cfg_q[CFG_BCAST_EN] && da_bc_q)) &&
                   sa_ok_q;
  // enable plus a frame type needed
  assign frame_hit = s_end_q && cfg_q[CFG_WAKE_EN] && addr_ok &&
                     (magic_hit || pass_hit || pat_hit);
  assign wake_now = frame_hit && s_crc_q;
  assign crc_drop = frame_hit && !s_crc_q;

  ////////////////////////////////////////////////////////////////////////
  // registers and wake outputs
  logic [3:0] stat_q, stat_d, pcnt_q, pcnt_d, gpio_q, gpio_d;
  logic irq_en_q, irq_en_d, pend_q, pend_d, lvl_q, lvl_d, flag_q, flag_d;
  logic [15:0] rdata_q, rdata_d;
  logic wr_cfg, rd_stat, rd_irq;

  assign wr_cfg = reg_wr && reg_addr == ADDR_WAKE_RX_CONFIG;
  assign rd_stat = reg_rd && reg_addr == ADDR_WAKE_RX_STATUS;
  assign rd_irq = reg_rd && reg_addr == ADDR_IRQ_STATUS_TWO;

  always_comb begin
    cfg_d = cfg_q;
    irq_en_d = irq_en_q;
    if (wr_cfg) begin
      cfg_d = reg_wdata;
      cfg_d[CFG_LEVEL_CLR] = 1'b0;
    end
    if (reg_wr && reg_addr == ADDR_IRQ_STATUS_TWO) begin
      irq_en_d = reg_wdata[IRQ_WAKE_EN];
    end
    // sticky results, clear on read, set wins
    stat_d = (rd_stat ? STAT_RESET : stat_q) |
             {crc_drop, pat_hit && wake_now, pass_hit && wake_now,
              magic_hit && wake_now};
    // pending flag, clear on read, set wins
    pend_d = (pend_q && !rd_irq) || (wake_now && irq_en_q);
    flag_d = pend_d;
    // pulse or level on chosen pin
    pcnt_d = (pcnt_q != 4'h0) ? pcnt_q - 4'h1 : 4'h0;
    lvl_d = lvl_q && !(wr_cfg && reg_wdata[CFG_LEVEL_CLR]);
    if (wake_now && cfg_q[CFG_PIN_EN]) begin
      if (cfg_q[CFG_LEVEL_MODE]) begin
        lvl_d = 1'b1;
      end else begin
        pcnt_d = PULSE_CYCLES;
      end
    end
    gpio_d = (lvl_d || pcnt_d != 4'h0) ?
             4'h1 << cfg_q[CFG_PIN_SEL +: 2] : 4'h0;
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_WAKE_RX_CONFIG: rdata_d = cfg_q;
        ADDR_WAKE_RX_STATUS: rdata_d = {12'h000, stat_q};
        ADDR_IRQ_STATUS_TWO: rdata_d = {7'h00, pend_q, 7'h00, irq_en_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RESET;
      irq_en_q <= 1'b0;
      stat_q <= STAT_RESET;
      pend_q <= 1'b0;
      flag_q <= 1'b0;
      pcnt_q <= 4'h0;
      lvl_q <= 1'b0;
      gpio_q <= 4'h0;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q <= cfg_d;
      irq_en_q <= irq_en_d;
      stat_q <= stat_d;
      pend_q <= pend_d;
      flag_q <= flag_d;
      pcnt_q <= pcnt_d;
      lvl_q <= lvl_d;
      gpio_q <= gpio_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign wake_gpio = gpio_q;
  assign wake_flag = flag_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_sync_done;
    st_q == WFD_SYNC && cnt_q == SYNC_LEN && s_vld_q && !s_end_q;
  endsequence
  sequence s_addr_start;
    st_q == WFD_ADDR && cnt_q == 3'h1 && rep_q == 4'h0;
  endsequence

  a_sync_before_addr: assert property (
    $rose(st_q == WFD_ADDR) |-> $past(cnt_q) == SYNC_LEN)
    else $error("address run entered without full sync run");
  a_sync_to_addr: assert property (
    s_sync_done ##0 (s_byte_q == pick_byte(node_addr, 3'h0))
    |=> s_addr_start)
    else $error("address run not started after sync");
  a_addr_reps_full: assert property (
    st_q == WFD_ADDR && (st_d == WFD_PASS || st_d == WFD_FOUND)
    |-> rep_q == REPS_LAST && cnt_q == ADDR_LAST)
    else $error("address run left early");
  a_pass_before_found: assert property (
    $rose(st_q == WFD_FOUND) && cfg_q[CFG_PASS_EN]
    |-> $past(st_q) == WFD_PASS)
    else $error("password skipped");
  a_break_restarts: assert property (
    s_vld_q && !s_end_q && st_q == WFD_ADDR &&
    s_byte_q != pick_byte(node_addr, cnt_q)
    |=> st_q == WFD_SYNC && cnt_q == {2'b00, $past(is_ff)})
    else $error("broken run did not restart");
  a_crc_gate_hold: assert property (
    frame_hit && !s_crc_q |=> !$rose(flag_q) && stat_q[ST_CRC_DROP])
    else $error("bad crc frame raised wake");
  a_enable_alone: assert property (
    (cfg_q & CFG_TYPE_MASK) == 16'h0000 |-> !wake_now)
    else $error("wake without frame type enabled");
  a_pin_event: assert property (
    wake_now && cfg_q[CFG_PIN_EN] && !cfg_q[CFG_LEVEL_MODE]
    |=> (wake_gpio == 4'h1 << cfg_q[CFG_PIN_SEL +: 2]) [*8])
    else $error("wake pulse wrong pin or length");
  a_irq_flag_set: assert property (
    wake_now && irq_en_q |=> wake_flag && pend_q)
    else $error("wake interrupt flag not raised");
  a_status_read: assert property (
    rd_stat |=> reg_rdata == {12'h000, $past(stat_q)})
    else $error("status read mismatch");
endmodule // wfd_detector

// ---- test/wfd_host_model.sv ----
`timescale 1ns/1ps
module wfd_host_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] wake_gpio,
  output int width,
  output int wakes
);
  int run;
  // sleeping host: counts pin wake events and measures each one
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 0;
      width <= 0;
      wakes <= 0;
    end else if (wake_gpio != 4'h0) begin
      if (run == 0) wakes <= wakes + 1;
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule // wfd_host_model

// ---- test/wfd_detector_tb_top.sv ----
`timescale 1ns/1ps
module wfd_detector_tb_top;
  import wfd_pkg::*;
  logic sys_clk, arst_n, rx_byte_valid, rx_end, rx_crc_ok, pat_wr;
  logic reg_wr, reg_rd, irq_en, wake_flag;
  logic [7:0] rx_data, pat_data;
  logic [7:0] pat[64];
  logic [7:0] frm[$];
  logic [5:0] pat_addr;
  logic [47:0] node_addr, wake_password;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [3:0] wake_gpio;
  int fails, comparisons, cycles, pin_ev, width, wakes;
  wfd_detector DUT (.sys_clk(sys_clk), .arst_n(arst_n),
    .rx_byte_valid(rx_byte_valid), .rx_data(rx_data), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .node_addr(node_addr),
    .wake_password(wake_password), .pat_wr(pat_wr), .pat_addr(pat_addr),
    .pat_data(pat_data), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wake_gpio(wake_gpio), .wake_flag(wake_flag));
  wfd_host_model host (.sys_clk(sys_clk), .arst_n(arst_n),
    .wake_gpio(wake_gpio), .width(width), .wakes(wakes));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_pin(input logic [4:0] e, input logic [4:0] g);
    cmp_reg({11'h000, e}, {11'h000, g});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic push48(input logic [47:0] v);
    for (int i = 0; i < 6; i++) frm.push_back(v[47-8*i -: 8]);
  endtask
  // kind: 1 plain, 2 with password, 3 run broken by a new sync, 4 cut short
  task automatic mk(input logic [47:0] dst, input int kind);
    frm.delete();
    push48(dst);
    push48(48'({$urandom, $urandom}) & 48'hFEFF_FFFF_FFFF);
    repeat ($urandom_range(0, 20)) frm.push_back(8'($urandom));
    if (kind != 0) begin
      repeat (6) frm.push_back(SYNC_BYTE);
      repeat (kind == 4 || kind == 3 ? 15 : 16) push48(node_addr);
    end
    if (kind == 3) begin
      repeat (6) frm.push_back(SYNC_BYTE);
      repeat (16) push48(node_addr);
    end
    if (kind == 2) push48(wake_password);
    repeat (8) frm.push_back(8'($urandom));
  endtask
  task automatic send(input int gap, input bit crc);
    foreach (frm[i]) begin
      @(negedge sys_clk);
      rx_byte_valid = 1'b1;
      rx_data = frm[i];
      repeat (gap) begin
        @(negedge sys_clk);
        rx_byte_valid = 1'b0;
      end
    end
    @(negedge sys_clk);
    rx_byte_valid = 1'b0;
    rx_end = 1'b1;
    rx_crc_ok = crc;
    @(negedge sys_clk);
    rx_end = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ebyte(input int k);
    if (k < 6) return SYNC_BYTE;
    if (k < 102) return node_addr[47-8*((k-6)%6) -: 8];
    return wake_password[47-8*(k-102) -: 8];
  endfunction
  function automatic logic [3:0] model_st(input logic [15:0] c, input bit crc);
    logic [47:0] d;
    bit m, p, ok;
    int len;
    d = '0;
    m = 0;
    p = frm.size() >= 64;
    len = c[1] ? 108 : 102;
    for (int i = 0; i < 6; i++) d = {d[39:0], frm[i]};
    ok = c[7] && !frm[6][0] && (d == node_addr || (c[3] && d == '1));
    for (int j = 0; j + len <= frm.size(); j++) begin
      bit h;
      h = 1;
      for (int k = 0; k < len; k++) if (frm[j+k] !== ebyte(k)) h = 0;
      m |= h;
    end
    for (int k = 0; k < 64 && p; k++) if (frm[k] !== pat[k]) p = 0;
    m &= ok & c[0];
    p &= ok & c[2];
    if (!crc) return {m | p, 3'h0};
    return {1'b0, p, m & c[1], m & !c[1]};
  endfunction
  task automatic run_frame(input logic [15:0] c, input int gap, input bit crc);
    logic [3:0] st;
    logic [3:0] pin;
    logic [15:0] msk;
    bit w;
    st = model_st(c, crc);
    w = st[2:0] != 3'h0;
    pin = (w & c[5]) ? 4'h1 << c[9:8] : 4'h0;
    msk = c[1] ? 16'hFFFE : 16'hFFFF;
    if (pin != 4'h0) pin_ev++;
    reg_write(ADDR_WAKE_RX_CONFIG, c);
    reg_read(ADDR_WAKE_RX_CONFIG, rd);
    cmp_reg(c, rd);
    send(gap, crc);
    repeat (2) @(negedge sys_clk);
    cmp_pin({w & irq_en, pin}, {wake_flag, wake_gpio});
    reg_read(ADDR_WAKE_RX_STATUS, rd);
    cmp_reg({12'h000, st} & msk, rd & msk);
    if (w & irq_en) begin
      reg_read(ADDR_IRQ_STATUS_TWO, rd);
      cmp_reg(16'h0101, rd);
      @(negedge sys_clk);
      cmp_pin(5'h00, {wake_flag, 4'h0});
    end
    repeat (12) @(negedge sys_clk);
    if (c[4]) begin
      cmp_pin({1'b0, pin}, {1'b0, wake_gpio});
      reg_write(ADDR_WAKE_RX_CONFIG, c | 16'h0400);
      @(negedge sys_clk);
    end else if (pin != 4'h0) begin
      cmp_reg(16'(PULSE_CYCLES), 16'(width));
    end
    cmp_pin(5'h00, {1'b0, wake_gpio});
    cmp_reg(16'(pin_ev), 16'(wakes));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, rx_byte_valid, rx_end, rx_crc_ok, pat_wr, reg_wr, reg_rd} = '0;
    {rx_data, pat_data, pat_addr, reg_addr, reg_wdata, irq_en} = '0;
    pin_ev = $urandom(32'hFB4D4C7E);
    pin_ev = 0;
    node_addr = 48'({$urandom, $urandom}) & 48'h7FFF_FFFF_FFFF;
    wake_password = 48'({$urandom, $urandom});
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    reg_write(ADDR_WAKE_RX_STATUS, 16'hFFFF);
    reg_write(16'h0200, 16'hFFFF);
    reg_read(ADDR_IRQ_STATUS_TWO, rd);
    cmp_reg(16'h0000, rd);
    reg_read(ADDR_WAKE_RX_CONFIG, rd);
    cmp_reg(CFG_RESET, rd);
    reg_read(ADDR_WAKE_RX_STATUS, rd);
    cmp_reg(16'h0000, rd);
    reg_read(16'h0200, rd);
    cmp_reg(16'h0000, rd);
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      pat[i] = i < 6 ? node_addr[47-8*i -: 8] : 8'($urandom);
      if (i == 6) pat[i][0] = 1'b0;
      pat_wr = 1'b1;
      pat_addr = 6'(i);
      pat_data = pat[i];
    end
    @(negedge sys_clk);
    pat_wr = 1'b0;
    reg_write(ADDR_IRQ_STATUS_TWO, 16'h0001);
    irq_en = 1'b1;
    mk(node_addr, 1);
    run_frame(16'h0080, 0, 1);
    run_frame(16'h00A1, 0, 1);
    run_frame(16'h00A1, 9, 1);
    run_frame(16'h00A1, 0, 0);
    mk(node_addr, 3);
    run_frame(16'h00A1, 0, 1);
    mk(node_addr, 4);
    run_frame(16'h00A1, 0, 1);
    mk('1, 1);
    run_frame(16'h00A1, 0, 1);
    run_frame(16'h00A9, 0, 1);
    mk(node_addr ^ 48'h0000_0000_0100, 1);
    run_frame(16'h00A9, 0, 1);
    mk(node_addr, 2);
    run_frame(16'h00A3, 0, 1);
    mk(node_addr, 1);
    run_frame(16'h00A3, 0, 1);
    frm.delete();
    foreach (pat[i]) frm.push_back(pat[i]);
    repeat (10) frm.push_back(8'($urandom));
    run_frame(16'h00A4, 0, 1);
    frm[63] ^= 8'h01;
    run_frame(16'h00A4, 0, 1);
    mk(node_addr, 1);
    for (int s = 0; s < 4; s++) begin
      run_frame(16'h00B1 | 16'(s << 8), 0, 1);
    end
    reg_write(ADDR_IRQ_STATUS_TWO, 16'h0000);
    irq_en = 1'b0;
    run_frame(16'h0081, 0, 1);
    print_verdict();
  end
endmodule // wfd_detector_tb_top
